// *** srp_pkg.sv ***
// shared constants and types for the primary status register bank
package srp_pkg;
  // any-register addresses of the two status registers
  localparam logic [23:0] ADDR_PRI_NV = 24'h000000;
  localparam logic [23:0] ADDR_PRI_VOL = 24'h070000;
  localparam logic [23:0] ADDR_SEC_NV = 24'h000001;
  localparam logic [23:0] ADDR_SEC_VOL = 24'h070001;
  // primary status field positions
  localparam int BIT_LOCK = 7;
  localparam int BIT_RSVD = 6;
  localparam int BIT_TB = 5;
  localparam int BIT_BP_HI = 4;
  localparam int BIT_BP_LO = 2;
  localparam int BIT_WR_EN = 1;
  localparam int BIT_BUSY = 0;
  // secondary status field positions
  localparam int BIT_CRC_SUSPEND = 4;
  localparam int BIT_CRC_ABORT = 3;
  // bits that have a non-volatile backing copy
  localparam logic [7:0] PRI_NV_MASK = 8'hBC;
  // factory default of both copies and of the secondary register
  localparam logic [7:0] PRI_RESET = 8'h00;
  localparam logic [7:0] SEC_RESET = 8'h00;
  // block protect codes with special meaning
  localparam logic [2:0] BP_NONE = 3'h0;
  localparam logic [2:0] BP_FULL = 3'h7;
  // commands handed over by the decoder at frame end
  typedef enum logic [2:0] {
    SRP_CMD_NONE = 3'b000,
    SRP_CMD_WR_ENABLE = 3'b001,
    SRP_CMD_WRDI = 3'b010,
    SRP_CMD_WR_STATUS = 3'b011,
    SRP_CMD_WR_ANY = 3'b100,
    SRP_CMD_SWRST = 3'b101
  } srp_cmd_t;
  // kinds of register read
  typedef enum logic [1:0] {
    SRP_RD_PRIMARY = 2'b00,
    SRP_RD_SECONDARY = 2'b01,
    SRP_RD_ANY = 2'b10,
    SRP_RD_IDLE = 2'b11
  } srp_rd_t;
endpackage

// *** srp_sync.sv ***
// two-flop synchroniser for levels and toggles
`timescale 1ns/1ps
module srp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset of the receiving domain
  input wire logic clk_i,
  input wire logic rst_i,
  // asynchronous level in, synchronised level out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  // first stage is read only by the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule // srp_sync

// *** srp_link.sv ***
// serial-clock front end: command hand-over and status mirror for reads
`timescale 1ns/1ps
module srp_link (
  // serial clock domain
  input wire logic link_clk_i,
  input wire logic link_rst_i,
  // decoded command from the frame decoder
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire srp_pkg::srp_cmd_t cmd_kind_i,
  input wire logic [23:0] cmd_addr_i,
  input wire logic [7:0] cmd_data_i,
  // register read request and answer
  input wire srp_pkg::srp_rd_t rd_kind_i,
  input wire logic [23:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  output logic rd_hit_o,
  // command words towards the core domain
  output logic req_tog_o,
  output srp_pkg::srp_cmd_t req_kind_o,
  output logic [23:0] req_addr_o,
  output logic [7:0] req_data_o,
  input wire logic ack_tog_i,
  // status snapshot from the core domain
  input wire logic snap_tog_i,
  input wire logic [15:0] snap_data_i,
  output logic snap_ack_o
);
  logic ack_s;
  logic snap_s;
  logic [15:0] mirror_r;
  logic take_c;

  srp_sync #(.W(1), .RST_VAL(1'b0)) u_ack_sync (.clk_i(link_clk_i), .rst_i(link_rst_i), .d_i(ack_tog_i), .q_o(ack_s));
  srp_sync #(.W(1), .RST_VAL(1'b0)) u_snap_sync (.clk_i(link_clk_i), .rst_i(link_rst_i), .d_i(snap_tog_i), .q_o(snap_s));

  // a new command waits until the core has taken the previous one
  assign cmd_ready_o = (ack_s == req_tog_o);
  assign take_c = cmd_valid_i & cmd_ready_o;

  // command words stay still until the core acknowledges them
  always_ff @(posedge link_clk_i) begin
    if (link_rst_i) begin
      req_tog_o <= 1'b0;
      req_kind_o <= srp_pkg::SRP_CMD_NONE;
      req_addr_o <= 24'h000000;
      req_data_o <= 8'h00;
    end else if (take_c) begin
      req_tog_o <= ~req_tog_o;
      req_kind_o <= cmd_kind_i;
      req_addr_o <= cmd_addr_i;
      req_data_o <= cmd_data_i;
    end
  end

  // the snapshot word is stable by the time its toggle arrives here
  always_ff @(posedge link_clk_i) begin
    if (link_rst_i) begin
      mirror_r <= {srp_pkg::SEC_RESET, srp_pkg::PRI_RESET};
      snap_ack_o <= 1'b0;
    end else if (snap_s != snap_ack_o) begin
      mirror_r <= snap_data_i;
      snap_ack_o <= snap_s;
    end
  end

  // primary status reads always answer from the volatile working copy
  always_ff @(posedge link_clk_i) begin
    if (link_rst_i) begin
      rd_data_o <= 8'h00;
      rd_hit_o <= 1'b0;
    end else begin
      rd_data_o <= 8'h00;
      rd_hit_o <= 1'b1;
      case (rd_kind_i)
        srp_pkg::SRP_RD_PRIMARY: rd_data_o <= mirror_r[7:0];
        srp_pkg::SRP_RD_SECONDARY: rd_data_o <= mirror_r[15:8];
        srp_pkg::SRP_RD_ANY: begin
          if (rd_addr_i == srp_pkg::ADDR_PRI_NV || rd_addr_i == srp_pkg::ADDR_PRI_VOL) begin
            rd_data_o <= mirror_r[7:0];
          end else if (rd_addr_i == srp_pkg::ADDR_SEC_NV || rd_addr_i == srp_pkg::ADDR_SEC_VOL) begin
            rd_data_o <= mirror_r[15:8];
          end else begin
            rd_hit_o <= 1'b0;
          end
        end
        default: rd_hit_o <= 1'b0;
      endcase
    end
  end

  property p_rd_primary;
    @(posedge link_clk_i) disable iff (link_rst_i)
      (rd_kind_i == srp_pkg::SRP_RD_PRIMARY) |=> (rd_data_o == $past(mirror_r[7:0]) && rd_hit_o);
  endproperty
  a_rd_primary: assert property (p_rd_primary) else $error("primary read not from working copy");

  property p_rd_any_vol;
    @(posedge link_clk_i) disable iff (link_rst_i)
      (rd_kind_i == srp_pkg::SRP_RD_ANY && rd_addr_i == srp_pkg::ADDR_PRI_VOL)
        |=> (rd_data_o == $past(mirror_r[7:0]));
  endproperty
  a_rd_any_vol: assert property (p_rd_any_vol) else $error("any-register read of primary status wrong");
endmodule // srp_link

// *** srp_bank.sv ***
// primary status register bank with volatile and non-volatile copies
`timescale 1ns/1ps
// Function
// - power-up loads the factory default into both copies; any hardware reset copies non-volatile bits into the working copy
// - protection and configuration outputs come only from the working copy
// - volatile-only write changes the working copy, never the backing copy
// - non-volatile write changes both copies at once
// - every primary status read answers from the working copy
// - primary status written by write-status or any-register write, read by both reads
// - any-register write at 0x000000 is non-volatile, at 0x070000 volatile-only
// - any-register read at 0x000000 or 0x070000 returns primary status
// - secondary status is read-only; no write path touches it
// - eight bits: lock, reserved zero, top/bottom, three protect, write-enable, busy
// - only lock, top/bottom and protect bits have a backing copy
// - lock set and write-protect pin low ignores register writes
// - lock clear leaves register writes open whatever the pin
// - top/bottom one anchors protection at bottom, zero at top
// - three protect bits choose the write-protected address range
// - write-enable latch is read-only, one when enabled, zero after power-up
// - busy reads one while busy; crc state reported in secondary register
// - write-enable set only by enable command, cleared after register writes and resets
// - code one protects a sixty-fourth, doubling to half, seven protects all
module srp_bank #(
  parameter int ADDR_W = 20
) (
  // core clock and power-up reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // serial clock domain
  input wire logic LINK_CLK_I,
  input wire logic LINK_RESET_I,
  // decoded command at frame end, serial clock domain
  input wire logic CMD_VALID_I,
  output logic CMD_READY_O,
  input wire srp_pkg::srp_cmd_t CMD_KIND_I,
  input wire logic [23:0] CMD_ADDR_I,
  input wire logic [7:0] CMD_DATA_I,
  // register read, serial clock domain
  input wire srp_pkg::srp_rd_t RD_KIND_I,
  input wire logic [23:0] RD_ADDR_I,
  output logic [7:0] RD_DATA_O,
  output logic RD_HIT_O,
  // device pins
  input wire logic HW_RESET_N_I,
  input wire logic WP_N_I,
  // crc engine state, core domain
  input wire logic BUSY_I,
  input wire logic CRC_SUSPEND_I,
  input wire logic CRC_ABORT_I,
  // protection and status towards the array control
  output logic WRITE_EN_O,
  output logic REG_LOCKED_O,
  output logic PROT_EN_O,
  output logic [ADDR_W-1:0] PROT_START_O,
  output logic [ADDR_W-1:0] PROT_END_O,
  output logic [7:0] STATUS_O,
  output logic [7:0] STATUS_NV_O
);
  localparam logic [ADDR_W:0] ARRAY_SIZE = (ADDR_W+1)'(1) << ADDR_W;

  logic req_tog;
  logic ack_tog_r;
  logic req_s;
  srp_pkg::srp_cmd_t req_kind;
  logic [23:0] req_addr;
  logic [7:0] req_data;
  logic snap_tog_r;
  logic snap_ack;
  logic snap_ack_s;
  logic [15:0] snap_r;
  logic wp_n_s;
  logic hw_rst_n_s;
  logic [7:0] vol_r;
  logic [7:0] nv_r;
  logic [7:0] sr2_r;
  logic wr_en_r;
  logic busy_r;
  logic fire_c;
  logic hw_rst_c;
  logic locked_c;
  logic wr_ok_c;
  logic wr_nv_c;
  logic wr_vol_c;
  logic reg_wr_c;
  logic [7:0] status_c;
  logic [2:0] bp_c;
  logic [ADDR_W:0] size_c;

  // serial-clock front end
  srp_link u_link (
    .link_clk_i(LINK_CLK_I),
    .link_rst_i(LINK_RESET_I),
    .cmd_valid_i(CMD_VALID_I),
    .cmd_ready_o(CMD_READY_O),
    .cmd_kind_i(CMD_KIND_I),
    .cmd_addr_i(CMD_ADDR_I),
    .cmd_data_i(CMD_DATA_I),
    .rd_kind_i(RD_KIND_I),
    .rd_addr_i(RD_ADDR_I),
    .rd_data_o(RD_DATA_O),
    .rd_hit_o(RD_HIT_O),
    .req_tog_o(req_tog),
    .req_kind_o(req_kind),
    .req_addr_o(req_addr),
    .req_data_o(req_data),
    .ack_tog_i(ack_tog_r),
    .snap_tog_i(snap_tog_r),
    .snap_data_i(snap_r),
    .snap_ack_o(snap_ack)
  );

  // pins and toggles from other domains pass two flops first
  srp_sync #(.W(1), .RST_VAL(1'b0)) u_req_sync (.clk_i(CLK_I), .rst_i(RESET_I), .d_i(req_tog), .q_o(req_s));
  srp_sync #(.W(1), .RST_VAL(1'b0)) u_snap_sync (.clk_i(CLK_I), .rst_i(RESET_I), .d_i(snap_ack), .q_o(snap_ack_s));
  srp_sync #(.W(1), .RST_VAL(1'b1)) u_wp_sync (.clk_i(CLK_I), .rst_i(RESET_I), .d_i(WP_N_I), .q_o(wp_n_s));
  srp_sync #(.W(1), .RST_VAL(1'b1)) u_rst_sync (.clk_i(CLK_I), .rst_i(RESET_I), .d_i(HW_RESET_N_I), .q_o(hw_rst_n_s));

  // a command is due when the synchronised toggle moves
  assign fire_c = req_s ^ ack_tog_r;
  assign hw_rst_c = ~hw_rst_n_s | (fire_c & (req_kind == srp_pkg::SRP_CMD_SWRST));

  // lock only bites with the pin low; lock clear never protects
  assign locked_c = vol_r[srp_pkg::BIT_LOCK] & ~wp_n_s;
  assign reg_wr_c = fire_c & ((req_kind == srp_pkg::SRP_CMD_WR_STATUS) | (req_kind == srp_pkg::SRP_CMD_WR_ANY));
  // writes need the latch, no lock, no busy and no reset in progress
  assign wr_ok_c = reg_wr_c & wr_en_r & ~locked_c & ~busy_r & hw_rst_n_s;
  assign wr_nv_c = wr_ok_c & ((req_kind == srp_pkg::SRP_CMD_WR_STATUS) | (req_addr == srp_pkg::ADDR_PRI_NV));
  assign wr_vol_c = wr_ok_c & (req_kind == srp_pkg::SRP_CMD_WR_ANY) & (req_addr == srp_pkg::ADDR_PRI_VOL);

  // acknowledge every command once taken, even ignored ones
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      ack_tog_r <= 1'b0;
    end else begin
      ack_tog_r <= req_s;
    end
  end

  // backing copy; only the lock, top/bottom and protect bits exist here
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      nv_r <= srp_pkg::PRI_RESET;
    end else if (wr_nv_c) begin
      nv_r <= req_data & srp_pkg::PRI_NV_MASK;
    end
  end

  // working copy: reload on reset, take either write kind
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      vol_r <= srp_pkg::PRI_RESET;
    end else if (hw_rst_c) begin
      vol_r <= nv_r;
    end else if (wr_nv_c | wr_vol_c) begin
      vol_r <= req_data & srp_pkg::PRI_NV_MASK;
    end
  end

  // latch is set by the enable command alone; a reset in the same cycle wins over the set
  always_ff @(posedge CLK_I) begin
    if (RESET_I || hw_rst_c) begin
      wr_en_r <= 1'b0;
    end else if (fire_c && !busy_r) begin
      case (req_kind)
        srp_pkg::SRP_CMD_WR_ENABLE: wr_en_r <= 1'b1;
        srp_pkg::SRP_CMD_WRDI,
        srp_pkg::SRP_CMD_WR_STATUS,
        srp_pkg::SRP_CMD_WR_ANY: wr_en_r <= 1'b0;
        default: wr_en_r <= wr_en_r;
      endcase
    end
  end

  // crc engine state is sampled only; the write path has no access
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      busy_r <= 1'b0;
      sr2_r <= srp_pkg::SEC_RESET;
    end else begin
      busy_r <= BUSY_I;
      sr2_r <= srp_pkg::SEC_RESET;
      sr2_r[srp_pkg::BIT_CRC_SUSPEND] <= CRC_SUSPEND_I;
      sr2_r[srp_pkg::BIT_CRC_ABORT] <= CRC_ABORT_I;
    end
  end

  // read-only bits are spliced in from their own sources
  always_comb begin
    status_c = vol_r & srp_pkg::PRI_NV_MASK;
    status_c[srp_pkg::BIT_RSVD] = 1'b0;
    status_c[srp_pkg::BIT_WR_EN] = wr_en_r;
    status_c[srp_pkg::BIT_BUSY] = busy_r;
  end

  // new snapshot only after the link has taken the previous one
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      snap_r <= {srp_pkg::SEC_RESET, srp_pkg::PRI_RESET};
      snap_tog_r <= 1'b0;
    end else if (snap_ack_s == snap_tog_r && snap_r != {sr2_r, status_c}) begin
      snap_r <= {sr2_r, status_c};
      snap_tog_r <= ~snap_tog_r;
    end
  end

  // protected size: code one is a sixty-fourth, each step doubles
  always_comb begin
    bp_c = vol_r[srp_pkg::BIT_BP_HI:srp_pkg::BIT_BP_LO];
    if (bp_c == srp_pkg::BP_NONE) begin
      size_c = '0;
    end else if (bp_c == srp_pkg::BP_FULL) begin
      size_c = ARRAY_SIZE;
    end else begin
      size_c = ARRAY_SIZE >> (3'd7 - bp_c);
    end
  end

  // range anchored at top or bottom by the working copy only
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      PROT_EN_O <= 1'b0;
      PROT_START_O <= '0;
      PROT_END_O <= '0;
    end else begin
      PROT_EN_O <= (bp_c != srp_pkg::BP_NONE);
      if (vol_r[srp_pkg::BIT_TB]) begin
        PROT_START_O <= '0;
        PROT_END_O <= ADDR_W'(size_c - (ADDR_W+1)'(1));
      end else begin
        PROT_START_O <= ADDR_W'(ARRAY_SIZE - size_c);
        PROT_END_O <= '1;
      end
    end
  end

  // status outputs for the array control and observation
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      WRITE_EN_O <= 1'b0;
      REG_LOCKED_O <= 1'b0;
      STATUS_O <= srp_pkg::PRI_RESET;
      STATUS_NV_O <= srp_pkg::PRI_RESET;
    end else begin
      WRITE_EN_O <= wr_en_r;
      REG_LOCKED_O <= locked_c;
      STATUS_O <= status_c;
      STATUS_NV_O <= nv_r;
    end
  end

  sequence s_nv_write;
    wr_nv_c;
  endsequence

  sequence s_vol_write;
    wr_vol_c;
  endsequence

  property p_nv_write;
    @(posedge CLK_I) disable iff (RESET_I)
      s_nv_write |=> (nv_r == $past(req_data & srp_pkg::PRI_NV_MASK)) && (vol_r == nv_r);
  endproperty
  a_nv_write: assert property (p_nv_write) else $error("non-volatile write missed a copy");

  property p_vol_write;
    @(posedge CLK_I) disable iff (RESET_I)
      s_vol_write |=> $stable(nv_r) && (vol_r == $past(req_data & srp_pkg::PRI_NV_MASK));
  endproperty
  a_vol_write: assert property (p_vol_write) else $error("volatile write touched backing copy");

  property p_hw_reload;
    @(posedge CLK_I) disable iff (RESET_I)
      hw_rst_c |=> (vol_r == $past(nv_r)) && !wr_en_r;
  endproperty
  a_hw_reload: assert property (p_hw_reload) else $error("hardware reset did not reload working copy");

  property p_lock;
    @(posedge CLK_I) disable iff (RESET_I)
      (reg_wr_c && vol_r[srp_pkg::BIT_LOCK] && !wp_n_s && !hw_rst_c) |=> $stable(vol_r) && $stable(nv_r);
  endproperty
  a_lock: assert property (p_lock) else $error("locked register was written");

  property p_unlocked;
    @(posedge CLK_I) disable iff (RESET_I)
      (reg_wr_c && wr_en_r && !busy_r && hw_rst_n_s && !vol_r[srp_pkg::BIT_LOCK] &&
        (req_kind == srp_pkg::SRP_CMD_WR_STATUS || req_addr == srp_pkg::ADDR_PRI_NV ||
        req_addr == srp_pkg::ADDR_PRI_VOL)) |=> (vol_r == $past(req_data & srp_pkg::PRI_NV_MASK));
  endproperty
  a_unlocked: assert property (p_unlocked) else $error("unlocked write refused");

  property p_wr_en_clear;
    @(posedge CLK_I) disable iff (RESET_I)
      (reg_wr_c && !busy_r) |=> !wr_en_r ##1 (STATUS_O[srp_pkg::BIT_WR_EN] == 1'b0);
  endproperty
  a_wr_en_clear: assert property (p_wr_en_clear) else $error("latch not cleared after register write");

  property p_wr_en_set;
    @(posedge CLK_I) disable iff (RESET_I)
      (fire_c && req_kind == srp_pkg::SRP_CMD_WR_ENABLE && !busy_r && hw_rst_n_s) |=> wr_en_r ##1 WRITE_EN_O;
  endproperty
  a_wr_en_set: assert property (p_wr_en_set) else $error("enable command did not set latch");

  property p_ro_bits;
    @(posedge CLK_I) disable iff (RESET_I)
      (wr_nv_c || wr_vol_c) |=> ##1 (STATUS_O[srp_pkg::BIT_RSVD] == 1'b0) &&
        (STATUS_O[srp_pkg::BIT_WR_EN] == 1'b0) && (STATUS_O[srp_pkg::BIT_BUSY] == $past(busy_r));
  endproperty
  a_ro_bits: assert property (p_ro_bits) else $error("write reached a read-only bit");

  property p_sr2_ro;
    @(posedge CLK_I) disable iff (RESET_I)
      reg_wr_c |=> (sr2_r == {3'h0, $past(CRC_SUSPEND_I), $past(CRC_ABORT_I), 3'h0});
  endproperty
  a_sr2_ro: assert property (p_sr2_ro) else $error("secondary register altered by write");

  property p_top_sixtyfourth;
    @(posedge CLK_I) disable iff (RESET_I)
      (bp_c == 3'h1 && !vol_r[srp_pkg::BIT_TB]) |=> (PROT_START_O == ADDR_W'(ARRAY_SIZE - (ARRAY_SIZE >> 6))) &&
        (PROT_END_O == '1) && PROT_EN_O;
  endproperty
  a_top_sixtyfourth: assert property (p_top_sixtyfourth) else $error("top range for code one wrong");

  property p_bottom_half;
    @(posedge CLK_I) disable iff (RESET_I)
      (bp_c == 3'h6 && vol_r[srp_pkg::BIT_TB]) |=> (PROT_START_O == '0) &&
        (PROT_END_O == ADDR_W'((ARRAY_SIZE >> 1) - (ADDR_W+1)'(1)));
  endproperty
  a_bottom_half: assert property (p_bottom_half) else $error("bottom half range wrong");
endmodule // srp_bank

// *** srp_host.sv ***
// host-side model that issues decoded register commands and reads on the serial clock
`timescale 1ns/1ps
module srp_host (
  // serial clock
  input wire logic link_clk_i,
  // command hand-over
  input wire logic cmd_ready_i,
  output logic cmd_valid_o,
  output srp_pkg::srp_cmd_t cmd_kind_o,
  output logic [23:0] cmd_addr_o,
  output logic [7:0] cmd_data_o,
  // register reads
  output srp_pkg::srp_rd_t rd_kind_o,
  output logic [23:0] rd_addr_o,
  input wire logic [7:0] rd_data_i,
  input wire logic rd_hit_i
);
  // idle link at time zero
  initial begin
    cmd_valid_o = 1'b0;
    cmd_kind_o = srp_pkg::SRP_CMD_NONE;
    cmd_addr_o = 24'h000000;
    cmd_data_o = 8'h00;
    rd_kind_o = srp_pkg::SRP_RD_IDLE;
    rd_addr_o = 24'h000000;
  end

  // one command per frame; a new one waits until the bank has taken the last
  task automatic send_cmd(input srp_pkg::srp_cmd_t kind, input logic [23:0] addr, input logic [7:0] data,
                          output bit ok);
    int n;
    n = 0;
    @(negedge link_clk_i);
    while (cmd_ready_i !== 1'b1 && n < 32) begin
      @(negedge link_clk_i);
      n++;
    end
    ok = (n < 32);
    cmd_kind_o = kind;
    cmd_addr_o = addr;
    cmd_data_o = data;
    cmd_valid_o = 1'b1;
    @(posedge link_clk_i);
    @(negedge link_clk_i);
    cmd_valid_o = 1'b0;
    // released fields are scrambled so the bank cannot lean on stale values
    cmd_kind_o = srp_pkg::SRP_CMD_NONE;
    cmd_addr_o = ~addr;
    cmd_data_o = ~data;
  endtask

  // request held over two edges, answer taken once it has settled
  task automatic read_reg(input srp_pkg::srp_rd_t kind, input logic [23:0] addr, output logic [7:0] data,
                          output logic hit);
    @(negedge link_clk_i);
    rd_kind_o = kind;
    rd_addr_o = addr;
    repeat (2) @(posedge link_clk_i);
    @(negedge link_clk_i);
    data = rd_data_i;
    hit = rd_hit_i;
    rd_kind_o = srp_pkg::SRP_RD_IDLE;
    rd_addr_o = ~addr;
  endtask
endmodule // srp_host

// *** tb.sv ***
// self-checking bench for the primary status register bank
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb;
  logic clk, rst, lclk, lrst, cmd_valid, cmd_ready, rd_hit, hw_rst_n, wp_n, busy, susp, abrt, wen, locked, prot_en;
  logic [7:0] cmd_data, rd_data, status, status_nv;
  logic [23:0] cmd_addr, rd_addr;
  logic [19:0] p_start, p_end;
  srp_pkg::srp_cmd_t cmd_kind;
  srp_pkg::srp_rd_t rd_kind;
  int miscompares, tests_run;
  logic [7:0] vol_e, nv_e;
  logic wr_en_e, wp_e, busy_e, sus_e, abt_e;
  logic [15:0] lfsr;

  // core clock and a free-running serial clock of unrelated phase
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #7;
    forever #62.5 lclk = ~lclk;
  end

  srp_bank u_srp_bank (.CLK_I(clk), .RESET_I(rst), .LINK_CLK_I(lclk), .LINK_RESET_I(lrst),
    .CMD_VALID_I(cmd_valid), .CMD_READY_O(cmd_ready), .CMD_KIND_I(cmd_kind), .CMD_ADDR_I(cmd_addr),
    .CMD_DATA_I(cmd_data), .RD_KIND_I(rd_kind), .RD_ADDR_I(rd_addr), .RD_DATA_O(rd_data), .RD_HIT_O(rd_hit),
    .HW_RESET_N_I(hw_rst_n), .WP_N_I(wp_n), .BUSY_I(busy), .CRC_SUSPEND_I(susp), .CRC_ABORT_I(abrt),
    .WRITE_EN_O(wen), .REG_LOCKED_O(locked), .PROT_EN_O(prot_en), .PROT_START_O(p_start),
    .PROT_END_O(p_end), .STATUS_O(status), .STATUS_NV_O(status_nv));
  srp_host u_srp_host (.link_clk_i(lclk), .cmd_ready_i(cmd_ready), .cmd_valid_o(cmd_valid),
    .cmd_kind_o(cmd_kind), .cmd_addr_o(cmd_addr), .cmd_data_o(cmd_data), .rd_kind_o(rd_kind),
    .rd_addr_o(rd_addr), .rd_data_i(rd_data), .rd_hit_i(rd_hit));

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // last protected offset from the end that top/bottom picks
  function automatic logic [19:0] span(input logic [2:0] bp);
    return (bp == 3'h7) ? 20'hFFFFF : 20'((32'h1 << (13 + bp)) - 32'h1);
  endfunction

  task automatic print_verdict();
    if (miscompares == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // long enough for both clock crossings and the status mirror
  task automatic settle();
    repeat (8) @(negedge lclk);
  endtask

  task automatic cmd(input srp_pkg::srp_cmd_t k, input logic [23:0] a, input logic [7:0] d);
    bit ok;
    u_srp_host.send_cmd(k, a, d, ok);
    `CHK(ok, 1'b1)
    settle();
  endtask

  task automatic pin_reset();
    @(negedge clk);
    hw_rst_n = 1'b0;
    repeat (4) @(negedge clk);
    hw_rst_n = 1'b1;
    settle();
  endtask

  task automatic check_all();
    logic [7:0] d, st;
    logic h;
    logic [19:0] sz;
    st = (vol_e & srp_pkg::PRI_NV_MASK) | {6'h00, wr_en_e, busy_e};
    sz = span(vol_e[4:2]);
    `CHK(status, st)
    `CHK(status_nv, nv_e)
    `CHK(wen, wr_en_e)
    `CHK(locked, vol_e[7] & ~wp_e)
    `CHK(prot_en, vol_e[4:2] != 3'h0)
    if (vol_e[4:2] != 3'h0) begin
      `CHK(p_start, vol_e[5] ? 20'h00000 : 20'hFFFFF - sz)
      `CHK(p_end, vol_e[5] ? sz : 20'hFFFFF)
    end
    u_srp_host.read_reg(srp_pkg::SRP_RD_PRIMARY, 24'h000000, d, h);
    `CHK({h, d}, {1'b1, st})
    u_srp_host.read_reg(srp_pkg::SRP_RD_ANY, lfsr[11] ? 24'h070000 : 24'h000000, d, h);
    `CHK({h, d}, {1'b1, st})
    u_srp_host.read_reg(srp_pkg::SRP_RD_SECONDARY, 24'h000000, d, h);
    `CHK({h, d}, {1'b1, 3'h0, sus_e, abt_e, 3'h0})
    u_srp_host.read_reg(srp_pkg::SRP_RD_ANY, lfsr[12] ? srp_pkg::ADDR_SEC_VOL : srp_pkg::ADDR_SEC_NV, d, h);
    `CHK({h, d}, {1'b1, 3'h0, sus_e, abt_e, 3'h0})
    u_srp_host.read_reg(srp_pkg::SRP_RD_ANY, 24'h123456, d, h);
    `CHK({h, d}, 9'h000)
  endtask

  // hang guard: 48 rounds of about 50 link cycles take near 300 us, so 600 us is ample
  initial begin
    #600000;
    miscompares++;
    print_verdict();
  end

  // reset, then random command mix with every command kind and pin state
  initial begin
    logic [2:0] op;
    logic [7:0] d;
    logic ok;
    srp_pkg::srp_cmd_t k;
    logic [23:0] a;
    {rst, lrst, hw_rst_n, wp_n, busy, susp, abrt} = 7'b1111000;
    {vol_e, nv_e, wr_en_e, wp_e, busy_e, sus_e, abt_e} = {16'h0000, 5'b01000};
    lfsr = 16'd2817;
    miscompares = 0;
    tests_run = 0;
    repeat (3) @(negedge lclk);
    lrst = 1'b0;
    // core reset leaves on its own falling edge, after the link side
    @(negedge clk);
    rst = 1'b0;
    settle();
    check_all();
    for (int i = 0; i < 48; i++) begin
      lfsr = lfsr_next(lfsr);
      op = lfsr[2:0];
      d = lfsr[15:8];
      {wp_e, sus_e, abt_e} = lfsr[5:3];
      busy_e = (lfsr[8:6] == 3'h0);
      @(negedge clk);
      {wp_n, susp, abrt, busy} = {wp_e, sus_e, abt_e, busy_e};
      settle();
      if (lfsr[4] | lfsr[9]) begin
        cmd(srp_pkg::SRP_CMD_WR_ENABLE, 24'h000000, 8'h00);
        wr_en_e = wr_en_e | ~busy_e;
        `CHK(wen, wr_en_e)
      end
      ok = wr_en_e & ~busy_e & ~(vol_e[7] & ~wp_e);
      k = (op == 3'd0) ? srp_pkg::SRP_CMD_WR_STATUS : (op == 3'd4) ? srp_pkg::SRP_CMD_SWRST :
          (op == 3'd6) ? srp_pkg::SRP_CMD_WRDI : srp_pkg::SRP_CMD_WR_ANY;
      // code 7 becomes a second volatile-only write; secondary address proves it read-only
      a = (op == 3'd1) ? srp_pkg::ADDR_PRI_NV : (op == 3'd3) ? srp_pkg::ADDR_SEC_NV : srp_pkg::ADDR_PRI_VOL;
      if (op == 3'd5) pin_reset();
      else cmd(k, a, d);
      if (ok && op <= 3'd1) nv_e = d & srp_pkg::PRI_NV_MASK;
      if (ok && (op <= 3'd2 || op == 3'd7)) vol_e = d & srp_pkg::PRI_NV_MASK;
      // protocol reset is still obeyed while busy, unlike every other command
      if (op == 3'd5 || op == 3'd4) vol_e = nv_e;
      if (op == 3'd5 || op == 3'd4 || !busy_e) wr_en_e = 1'b0;
      check_all();
    end
    print_verdict();
  end
endmodule // tb
